/* tfc_pkg.sv */
// Constants for the translation control and fault capture registers
package tfc_pkg;
    // Register selectors on the coprocessor move port (register, select)
    localparam logic [7:0] SEL_PAGE_MASK = 8'h28;
    localparam logic [7:0] SEL_GRAIN = 8'h29;
    localparam logic [7:0] SEL_BOUNDARY = 8'h30;
    localparam logic [7:0] SEL_HW_MASK = 8'h38;
    localparam logic [7:0] SEL_FAULT_VADDR = 8'h40;
    localparam logic [7:0] SEL_FAULT_INSTR = 8'h41;
    // Page size mask layout
    localparam int PM_LSB = 13;
    localparam int PM_MSB = 28;
    localparam int PM_PAIRS = 8;
    // Implemented page sizes, one bit per pair from 16 KB upward
    localparam logic [7:0] PM_SUPPORTED = 8'h0f;
    // Page granularity control fields
    localparam int PG_RIE = 31;
    localparam int PG_XIE = 30;
    localparam int PG_LPA = 29;
    localparam int PG_IEC = 27;
    localparam logic PG_LPA_RESET = 1'b0;
    // Boundary and access mask layout
    localparam int BOUND_W = 5;
    localparam logic [4:0] BOUND_RESET = 5'h00;
    localparam logic [4:0] RANDOM_UPPER = 5'h1f;
    localparam int HW_TP_BIT = 29;
    localparam logic [3:0] HW_MASK_RESET = 4'h0;
    localparam logic HW_TP_RESET = 1'b0;
    localparam logic [4:0] HW_TP_INDEX = 5'h1d;
    // Frame number extension width
    localparam int FRAME_NUMBER_EXTENSION_W = 4;
    // Exception classes reported by the pipeline
    typedef enum logic [3:0] {
        TFC_EXC_NONE, TFC_EXC_ADDR_ERR, TFC_EXC_REFILL, TFC_EXC_INVALID,
        TFC_EXC_MODIFIED, TFC_EXC_READ_INH, TFC_EXC_EXEC_INH,
        TFC_EXC_EXECUTION, TFC_EXC_INTERRUPT, TFC_EXC_NMI,
        TFC_EXC_MCHECK, TFC_EXC_BUS_ERR, TFC_EXC_CACHE_ERR, TFC_EXC_DEBUG
    } tfc_exc_t;
endpackage

/* tfc_regs.sv */
// Translation control and fault capture coprocessor register bank
`timescale 1ns/1ns

// Rules for this block and the software that drives it
// [R1] Smallest page size encoding always all zeros
// [R2] Page sizes are contiguous ones pairs upward
// [R3] Unimplemented page size pairs read zero
// [R4] Software probes sizes by all-ones write
// [R5] Software loads only listed mask encodings
// [R6] Software flushes buffer before granularity change
// [R7] Inhibit enables read-only, reset one, gate writes
// [R8] Large address enable writable, unlocks frame extension
// [R9] Extension writes ignored, reads zero when disabled
// [R10] Unique inhibit exception codes bit reads one
// [R11] Reserved bits ignore writes, read zero
// [R12] Random writes never replace wired entries
// [R13] Wired boundary clears to zero on reset
// [R14] Boundary write sets random pointer upper
// [R15] Software keeps boundary below entry count
// [R16] Access mask bit n permits register n
// [R17] Mask bit 29 grants thread pointer reads
// [R18] Denied hardware register read raises exception
// [R19] Fault address captured for addressing exceptions
// [R20] Fault instruction captured on synchronous exceptions
// [R21] Asynchronous exceptions leave fault instruction alone
// [R22] Short instructions zero extended from bit 15
// [R23] Read inhibited page read raises invalid
// [R24] Access only by privileged move, effect next
module tfc_regs
    import tfc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Privileged coprocessor move port
    input wire logic mv_wr_in,
    input wire logic mv_rd_in,
    input wire logic mv_priv_in,
    input wire logic [7:0] mv_sel_in,
    input wire logic [31:0] mv_wdata_in,
    output logic [31:0] mv_rdata_out,
    // Large physical address capability strap-like input
    input wire logic large_phys_capable_in,
    // Entry low extension and inhibit write path
    input wire logic entry_low_wr_in,
    input wire logic [FRAME_NUMBER_EXTENSION_W-1:0] frame_number_extension_in,
    input wire logic read_inhibit_in,
    input wire logic exec_inhibit_in,
    output logic [FRAME_NUMBER_EXTENSION_W-1:0] frame_number_extension_out,
    output logic read_inhibit_out,
    output logic exec_inhibit_out,
    // Buffer write pointer
    input wire logic random_entry_write_in,
    input wire logic indexed_entry_write_in,
    input wire logic [4:0] index_in,
    output logic [4:0] write_index_out,
    output logic write_strobe_out,
    // Hardware register read check
    input wire logic read_hw_register_in,
    input wire logic [4:0] hw_reg_num_in,
    output logic hw_reg_grant_out,
    output logic reserved_instr_exc_out,
    // Data read check against inhibit
    input wire logic data_read_in,
    input wire logic page_read_inhibit_in,
    input wire logic page_valid_in,
    output logic invalid_exc_out,
    // Exception capture
    input wire logic exc_valid_in,
    input wire tfc_exc_t exc_class_in,
    input wire logic [31:0] exc_vaddr_in,
    input wire logic [31:0] exc_instr_in,
    input wire logic exc_instr_short_in,
    input wire logic exc_instr_valid_in,
    // Register views
    output logic [31:0] page_size_mask_out,
    output logic unique_inhibit_codes_out
);

    logic [PM_PAIRS-1:0] pm_pairs;
    logic large_phys_addr_enable;
    logic [4:0] boundary;
    logic [4:0] random_ptr;
    logic [3:0] hw_mask;
    logic thread_pointer_access;
    logic [31:0] faulting_vaddr;
    logic [31:0] faulting_instr_word;
    logic [FRAME_NUMBER_EXTENSION_W-1:0] frame_number_extension;
    logic ri_bit;
    logic xi_bit;
    logic wr_ok;
    logic lpa_on;
    logic [31:0] next_rdata;
    logic [31:0] pm_view;
    logic [31:0] pg_view;
    logic hw_allowed;
    logic [4:0] next_random;

    assign wr_ok = mv_wr_in && mv_priv_in; // [R24]
    assign lpa_on = large_phys_addr_enable && large_phys_capable_in; // [R8]

    // Pairs are stored only where implemented; the rest read zero
    genvar gi;
    generate
        for (gi = 0; gi < PM_PAIRS; gi++)
        begin : g_pair
            always_ff @(posedge clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    pm_pairs[gi] <= 1'b0; // [R1]
                else if (wr_ok && mv_sel_in == SEL_PAGE_MASK)
                    pm_pairs[gi] <= PM_SUPPORTED[gi]
                        && (&mv_wdata_in[PM_LSB+2*gi+1 -: 2]); // [R3]
            end
            assign pm_view[PM_LSB+2*gi+1 -: 2] = {2{pm_pairs[gi]}}; // [R2]
        end
    endgenerate
    assign pm_view[PM_LSB-1:0] = '0; // [R11]
    assign pm_view[31:PM_MSB+1] = '0; // [R11]

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            large_phys_addr_enable <= PG_LPA_RESET;
        else if (wr_ok && mv_sel_in == SEL_GRAIN)
            large_phys_addr_enable <= mv_wdata_in[PG_LPA]; // [R8]
    end

    always_comb
    begin
        pg_view = '0; // [R11]
        pg_view[PG_RIE] = 1'b1; // [R7]
        pg_view[PG_XIE] = 1'b1; // [R7]
        pg_view[PG_LPA] = large_phys_addr_enable;
        pg_view[PG_IEC] = 1'b1; // [R10]
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            boundary <= BOUND_RESET; // [R13]
        else if (wr_ok && mv_sel_in == SEL_BOUNDARY)
            boundary <= mv_wdata_in[BOUND_W-1:0]; // [R11]
    end

    // Random pointer counts down and wraps to the top at the boundary
    always_comb
    begin
        if (random_ptr <= boundary || random_ptr == 5'h00)
            next_random = RANDOM_UPPER;
        else
            next_random = random_ptr - 5'h01;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            random_ptr <= RANDOM_UPPER;
        else if (wr_ok && mv_sel_in == SEL_BOUNDARY)
            random_ptr <= RANDOM_UPPER; // [R14]
        else
            random_ptr <= next_random;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            write_index_out <= 5'h00;
            write_strobe_out <= 1'b0;
        end
        else if (indexed_entry_write_in)
        begin
            write_index_out <= index_in; // [R12]
            write_strobe_out <= 1'b1;
        end
        else if (random_entry_write_in)
        begin
            write_index_out <= (random_ptr < boundary) ? RANDOM_UPPER
                : random_ptr; // [R12]
            write_strobe_out <= 1'b1;
        end
        else
            write_strobe_out <= 1'b0;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            hw_mask <= HW_MASK_RESET;
            thread_pointer_access <= HW_TP_RESET;
        end
        else if (wr_ok && mv_sel_in == SEL_HW_MASK)
        begin
            hw_mask <= mv_wdata_in[3:0]; // [R16]
            thread_pointer_access <= mv_wdata_in[HW_TP_BIT]; // [R17]
        end
    end

    always_comb
    begin
        if (hw_reg_num_in == HW_TP_INDEX)
            hw_allowed = thread_pointer_access; // [R17]
        else if (hw_reg_num_in < 5'h04)
            hw_allowed = hw_mask[hw_reg_num_in[1:0]]; // [R16]
        else
            hw_allowed = 1'b0;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            hw_reg_grant_out <= 1'b0;
            reserved_instr_exc_out <= 1'b0;
        end
        else
        begin
            hw_reg_grant_out <= read_hw_register_in
                && (mv_priv_in || hw_allowed);
            reserved_instr_exc_out <= read_hw_register_in
                && !mv_priv_in && !hw_allowed; // [R18]
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            invalid_exc_out <= 1'b0;
        else
            invalid_exc_out <= data_read_in && page_valid_in
                && page_read_inhibit_in && pg_view[PG_RIE]; // [R23]
    end

    // Entry low extension and inhibit bits as gated by the controls
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            frame_number_extension <= '0;
            ri_bit <= 1'b0;
            xi_bit <= 1'b0;
        end
        else if (entry_low_wr_in)
        begin
            if (lpa_on)
                frame_number_extension <= frame_number_extension_in; // [R9]
            ri_bit <= read_inhibit_in && pg_view[PG_RIE]; // [R7]
            xi_bit <= exec_inhibit_in && pg_view[PG_XIE]; // [R7]
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            frame_number_extension_out <= '0;
            read_inhibit_out <= 1'b0;
            exec_inhibit_out <= 1'b0;
        end
        else
        begin
            frame_number_extension_out <= lpa_on ? frame_number_extension : '0; // [R9]
            read_inhibit_out <= ri_bit;
            exec_inhibit_out <= xi_bit;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            faulting_vaddr <= 32'h0000_0000;
        else if (exc_valid_in && (exc_class_in == TFC_EXC_ADDR_ERR
            || exc_class_in == TFC_EXC_REFILL
            || exc_class_in == TFC_EXC_INVALID
            || exc_class_in == TFC_EXC_MODIFIED))
            faulting_vaddr <= exc_vaddr_in; // [R19]
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            faulting_instr_word <= 32'h0000_0000;
        else if (exc_valid_in && exc_instr_valid_in
            && exc_class_in >= TFC_EXC_ADDR_ERR
            && exc_class_in <= TFC_EXC_EXECUTION) // [R20] [R21]
            faulting_instr_word <= exc_instr_short_in
                ? {16'h0000, exc_instr_in[15:0]} : exc_instr_in; // [R22]
    end

    always_comb
    begin
        unique case (mv_sel_in)
            SEL_PAGE_MASK: next_rdata = pm_view;
            SEL_GRAIN: next_rdata = pg_view;
            SEL_BOUNDARY: next_rdata = {27'h0, boundary}; // [R11]
            SEL_HW_MASK: next_rdata = {2'h0, thread_pointer_access,
                25'h0, hw_mask}; // [R11]
            SEL_FAULT_VADDR: next_rdata = faulting_vaddr;
            SEL_FAULT_INSTR: next_rdata = faulting_instr_word;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            mv_rdata_out <= 32'h0000_0000;
            page_size_mask_out <= 32'h0000_0000;
            unique_inhibit_codes_out <= 1'b1;
        end
        else
        begin
            if (mv_rd_in && mv_priv_in)
                mv_rdata_out <= next_rdata; // [R24]
            page_size_mask_out <= pm_view;
            unique_inhibit_codes_out <= pg_view[PG_IEC]; // [R10]
        end
    end

    AST_BOUND_RESET_RANDOM: assert property (@(posedge clk_in) // [R14]
        disable iff (!resetn_in)
        wr_ok && mv_sel_in == SEL_BOUNDARY |=> random_ptr == RANDOM_UPPER)
        else $error("random pointer not at top after boundary write");
    AST_RANDOM_ABOVE_WIRED: assert property (@(posedge clk_in) // [R12]
        disable iff (!resetn_in)
        random_entry_write_in && !indexed_entry_write_in
        |=> write_index_out >= $past(boundary))
        else $error("random write hit a wired entry");
    AST_PM_UNSUPPORTED_ZERO: assert property (@(posedge clk_in) // [R3]
        disable iff (!resetn_in)
        (pm_view[PM_MSB:PM_LSB+8]) == 8'h00)
        else $error("unimplemented page size bits read nonzero");
    AST_GRAIN_CONST: assert property (@(posedge clk_in) // [R7]
        disable iff (!resetn_in)
        pg_view[PG_RIE] && pg_view[PG_XIE] && pg_view[PG_IEC])
        else $error("read-only grain bits not one");
    AST_HW_DENY: assert property (@(posedge clk_in) // [R18]
        disable iff (!resetn_in)
        read_hw_register_in && !mv_priv_in && hw_reg_num_in == 5'h00
        && !hw_mask[0] |=> reserved_instr_exc_out && !hw_reg_grant_out)
        else $error("denied read did not raise exception");
    AST_VADDR_KEEP: assert property (@(posedge clk_in) // [R19]
        disable iff (!resetn_in)
        exc_valid_in && exc_class_in == TFC_EXC_BUS_ERR
        |=> $stable(faulting_vaddr))
        else $error("fault address changed on bus error");
    AST_INSTR_SHORT: assert property (@(posedge clk_in) // [R22]
        disable iff (!resetn_in)
        exc_valid_in && exc_instr_valid_in && exc_instr_short_in
        && exc_class_in == TFC_EXC_EXECUTION
        |=> faulting_instr_word[31:16] == 16'h0000)
        else $error("short instruction upper half not zero");
    AST_INSTR_ASYNC: assert property (@(posedge clk_in) // [R21]
        disable iff (!resetn_in)
        exc_valid_in && exc_class_in >= TFC_EXC_INTERRUPT
        |=> $stable(faulting_instr_word))
        else $error("fault instruction changed on async exception");
    AST_FRAME_NUMBER_EXTENSION_OFF: assert property (@(posedge clk_in) // [R9]
        disable iff (!resetn_in)
        !lpa_on |=> frame_number_extension_out == '0)
        else $error("frame extension visible while disabled");

    COV_BOUND_WRITE: cover property (@(posedge clk_in)
        wr_ok && mv_sel_in == SEL_BOUNDARY ##1 random_entry_write_in);
    COV_HW_DENIED: cover property (@(posedge clk_in)
        reserved_instr_exc_out);
    COV_PM_PROBE: cover property (@(posedge clk_in)
        wr_ok && mv_sel_in == SEL_PAGE_MASK && &mv_wdata_in);
endmodule

/* tb.sv */
// Self-checking testbench for the translation control register bank
`timescale 1ns/1ns
module tb;
    import tfc_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic mv_wr_in = 1'b0, mv_rd_in = 1'b0, mv_priv_in = 1'b0;
    logic [7:0] mv_sel_in = 8'h00;
    logic [31:0] mv_wdata_in = 32'h0, mv_rdata_out;
    logic large_phys_capable_in = 1'b1;
    logic entry_low_wr_in = 1'b0, read_inhibit_in = 1'b0;
    logic exec_inhibit_in = 1'b0, read_inhibit_out, exec_inhibit_out;
    logic [FRAME_NUMBER_EXTENSION_W-1:0] frame_number_extension_in = '0;
    logic [FRAME_NUMBER_EXTENSION_W-1:0] frame_number_extension_out;
    logic random_entry_write_in = 1'b0, indexed_entry_write_in = 1'b0;
    logic [4:0] index_in = 5'h00, write_index_out, hw_reg_num_in = 5'h00;
    logic write_strobe_out, read_hw_register_in = 1'b0;
    logic hw_reg_grant_out, reserved_instr_exc_out, invalid_exc_out;
    logic data_read_in = 1'b0, page_read_inhibit_in = 1'b0;
    logic page_valid_in = 1'b0, exc_valid_in = 1'b0;
    tfc_exc_t exc_class_in = TFC_EXC_NONE;
    logic [31:0] exc_vaddr_in = 32'h0, exc_instr_in = 32'h0;
    logic exc_instr_short_in = 1'b0, exc_instr_valid_in = 1'b0;
    logic [31:0] page_size_mask_out, ev, ei;
    logic unique_inhibit_codes_out;
    int n_fail = 0, n_checks = 0, cycles = 0;

    tfc_regs dut (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .mv_wr_in(mv_wr_in),
        .mv_rd_in(mv_rd_in),
        .mv_priv_in(mv_priv_in),
        .mv_sel_in(mv_sel_in),
        .mv_wdata_in(mv_wdata_in),
        .mv_rdata_out(mv_rdata_out),
        .large_phys_capable_in(large_phys_capable_in),
        .entry_low_wr_in(entry_low_wr_in),
        .frame_number_extension_in(frame_number_extension_in),
        .read_inhibit_in(read_inhibit_in),
        .exec_inhibit_in(exec_inhibit_in),
        .frame_number_extension_out(frame_number_extension_out),
        .read_inhibit_out(read_inhibit_out),
        .exec_inhibit_out(exec_inhibit_out),
        .random_entry_write_in(random_entry_write_in),
        .indexed_entry_write_in(indexed_entry_write_in),
        .index_in(index_in),
        .write_index_out(write_index_out),
        .write_strobe_out(write_strobe_out),
        .read_hw_register_in(read_hw_register_in),
        .hw_reg_num_in(hw_reg_num_in),
        .hw_reg_grant_out(hw_reg_grant_out),
        .reserved_instr_exc_out(reserved_instr_exc_out),
        .data_read_in(data_read_in),
        .page_read_inhibit_in(page_read_inhibit_in),
        .page_valid_in(page_valid_in),
        .invalid_exc_out(invalid_exc_out),
        .exc_valid_in(exc_valid_in),
        .exc_class_in(exc_class_in),
        .exc_vaddr_in(exc_vaddr_in),
        .exc_instr_in(exc_instr_in),
        .exc_instr_short_in(exc_instr_short_in),
        .exc_instr_valid_in(exc_instr_valid_in),
        .page_size_mask_out(page_size_mask_out),
        .unique_inhibit_codes_out(unique_inhibit_codes_out)
    );

    always #4 clk_in = ~clk_in;

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Cut a hang short well past the expected run length
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] sel, input logic [31:0] d,
                      input logic priv = 1'b1);
        @(negedge clk_in);
        mv_priv_in = priv;
        mv_sel_in = sel;
        mv_wdata_in = d;
        mv_wr_in = 1'b1;
        @(negedge clk_in);
        mv_wr_in = 1'b0;
        mv_priv_in = 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] sel, input logic [31:0] exp);
        @(negedge clk_in);
        mv_priv_in = 1'b1;
        mv_sel_in = sel;
        mv_rd_in = 1'b1;
        @(negedge clk_in);
        mv_rd_in = 1'b0;
        mv_priv_in = 1'b0;
        check(mv_rdata_out, exp);
    endtask

    task automatic hwrd(input logic [4:0] num, input logic g);
        @(negedge clk_in);
        read_hw_register_in = 1'b1;
        hw_reg_num_in = num;
        @(negedge clk_in);
        read_hw_register_in = 1'b0;
        check(hw_reg_grant_out, g);
        check(reserved_instr_exc_out, !g);
    endtask

    task automatic el(input logic [3:0] x, input logic ri, input logic xi);
        @(negedge clk_in);
        entry_low_wr_in = 1'b1;
        frame_number_extension_in = x;
        read_inhibit_in = ri;
        exec_inhibit_in = xi;
        @(negedge clk_in);
        entry_low_wr_in = 1'b0;
        @(negedge clk_in);
    endtask

    task automatic exc(input logic [3:0] c, input logic [31:0] va,
                       input logic [31:0] ins, input logic sh);
        @(negedge clk_in);
        exc_valid_in = 1'b1;
        exc_class_in = tfc_exc_t'(c);
        exc_vaddr_in = va;
        exc_instr_in = ins;
        exc_instr_short_in = sh;
        exc_instr_valid_in = 1'b1;
        @(negedge clk_in);
        exc_valid_in = 1'b0;
    endtask

    initial
    begin
        repeat (16) @(negedge clk_in);
        resetn_in = 1'b1;
        check(unique_inhibit_codes_out, 1'b1);
        rdchk(SEL_GRAIN, 32'hc800_0000);
        rdchk(SEL_BOUNDARY, 32'h0);
        rdchk(SEL_HW_MASK, 32'h0);
        rdchk(8'h00, 32'h0);
        $display("reset values done");
        // Four pairs implemented: 16 KB up to 1 MB, bits 20:13
        wr(SEL_PAGE_MASK, 32'hffff_ffff);
        rdchk(SEL_PAGE_MASK, 32'h001f_e000);
        check(page_size_mask_out, 32'h001f_e000);
        wr(SEL_PAGE_MASK, 32'h0000_6000);
        rdchk(SEL_PAGE_MASK, 32'h0000_6000);
        wr(SEL_PAGE_MASK, 32'h0);
        rdchk(SEL_PAGE_MASK, 32'h0);
        $display("page mask done");
        wr(SEL_GRAIN, 32'hffff_ffff);
        rdchk(SEL_GRAIN, 32'he800_0000);
        el(4'ha, 1'b1, 1'b1);
        check(frame_number_extension_out, 4'ha);
        check(read_inhibit_out, 1'b1);
        check(exec_inhibit_out, 1'b1);
        wr(SEL_GRAIN, 32'h0);
        rdchk(SEL_GRAIN, 32'hc800_0000);
        el(4'h5, 1'b0, 1'b0);
        check(frame_number_extension_out, 4'h0);
        check(read_inhibit_out, 1'b0);
        // Enable set but capability absent: extension stays dark
        large_phys_capable_in = 1'b0;
        wr(SEL_GRAIN, 32'h2000_0000);
        el(4'h3, 1'b0, 1'b0);
        check(frame_number_extension_out, 4'h0);
        large_phys_capable_in = 1'b1;
        wr(SEL_GRAIN, 32'h0);
        $display("granularity done");
        wr(SEL_BOUNDARY, 32'hffff_ffff);
        rdchk(SEL_BOUNDARY, 32'h0000_001f);
        wr(SEL_BOUNDARY, 32'h0000_0005);
        random_entry_write_in = 1'b1;
        @(negedge clk_in);
        random_entry_write_in = 1'b0;
        check(write_strobe_out, 1'b1);
        check(write_index_out, RANDOM_UPPER);
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk_in);
            random_entry_write_in = 1'b1;
            @(negedge clk_in);
            random_entry_write_in = 1'b0;
            check(write_index_out >= 5'h05, 1'b1);
        end
        @(negedge clk_in);
        indexed_entry_write_in = 1'b1;
        random_entry_write_in = 1'b1;
        index_in = 5'h02;
        @(negedge clk_in);
        indexed_entry_write_in = 1'b0;
        random_entry_write_in = 1'b0;
        check(write_index_out, 5'h02);
        check(write_strobe_out, 1'b1);
        wr(SEL_BOUNDARY, 32'h0000_0009, 1'b0);
        rdchk(SEL_BOUNDARY, 32'h0000_0005);
        $display("boundary done");
        // Reset in mid-run must clear a nonzero boundary
        @(negedge clk_in);
        resetn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        resetn_in = 1'b1;
        rdchk(SEL_BOUNDARY, 32'h0);
        rdchk(SEL_GRAIN, 32'hc800_0000);
        $display("second reset done");
        wr(SEL_HW_MASK, 32'hffff_ffff);
        rdchk(SEL_HW_MASK, 32'h2000_000f);
        for (int n = 0; n < 4; n++)
            hwrd(n[4:0], 1'b1);
        hwrd(HW_TP_INDEX, 1'b1);
        hwrd(5'h04, 1'b0);
        wr(SEL_HW_MASK, 32'h0000_0005);
        hwrd(5'h01, 1'b0);
        hwrd(5'h02, 1'b1);
        hwrd(HW_TP_INDEX, 1'b0);
        // Privileged mode reads regardless of the mask
        mv_priv_in = 1'b1;
        hwrd(5'h04, 1'b1);
        mv_priv_in = 1'b0;
        $display("access mask done");
        @(negedge clk_in);
        data_read_in = 1'b1;
        page_read_inhibit_in = 1'b1;
        page_valid_in = 1'b1;
        @(negedge clk_in);
        page_read_inhibit_in = 1'b0;
        check(invalid_exc_out, 1'b1);
        @(negedge clk_in);
        data_read_in = 1'b0;
        check(invalid_exc_out, 1'b0);
        $display("read inhibit done");
        ev = 32'h0;
        ei = 32'h0;
        for (int c = 0; c < 14; c++)
        begin
            exc(c[3:0], 32'h0000_1000 + c, 32'habcd_0000 + c, 1'b0);
            if (c >= 1 && c <= 4)
                ev = 32'h0000_1000 + c;
            if (c >= 1 && c <= 7)
                ei = 32'habcd_0000 + c;
            rdchk(SEL_FAULT_VADDR, ev);
            rdchk(SEL_FAULT_INSTR, ei);
        end
        exc(4'h7, 32'h0, 32'h1234_abcd, 1'b1);
        rdchk(SEL_FAULT_INSTR, 32'h0000_abcd);
        $display("fault capture done");
        stop_test();
    end
endmodule
